// ==== verilog/scs_pkg.sv ====
// Behaviour
// - commands go out on four active-low lines, captured on the rising clock
// - encodings: nop 111, active 011, read 101, write 100, bt 110, pre 010
// - setting the bank valid bit issues load-mode with mode value on address
// - mode value uses fixed defaults, only cas latency comes from configuration
// - precharge before opening a different row in an open bank, or before refresh with any bank open
// - active carries the row only, no bank lines; skipped when the row is already open
// - write puts column on address while data bus carries the word
// - first read word is captured two or three clocks after read command
// - nops after read let the burst run, one word per clock edge
// - every read ends in burst terminate; memory drives two cycles more
// - burst terminate goes out on the last word, single reads included
// - while another device is accessed the sdram chip select stays high
// - at least two inhibit cycles follow burst terminate before other access
// - refresh has chip select, row and column strobes low
// - during active the a10 line carries address bit 20, 19 or 18
// - during precharge the a10 line is high, all banks close
// - during read and write the a10 line is low, no autoprecharge
// - halfword fetches from a 32-bit memory are single, never bursts
package scs_pkg;
	localparam int CLK_MHZ = 125;
	localparam int REFRESH_NS = 7800;
	localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
	localparam int INH_CYC = 2;
	localparam int MAX_LEN = 4;
	localparam int COL_W = 8;
	localparam int ROW_W = 14;
	localparam int AP_BIT = 10;
	localparam logic [1:0] PS_32 = 2'h0;
	localparam logic [1:0] PS_8 = 2'h1;
	localparam logic [1:0] PS_16 = 2'h2;
	localparam logic [2:0] MODE_BL = 3'h7;
	localparam logic MODE_BT = 1'b0;
	localparam logic MODE_WB = 1'b1;
	localparam logic [2:0] MODE_CL2 = 3'h2;
	localparam logic [2:0] MODE_CL3 = 3'h3;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} scs_cmd_t;
	localparam scs_cmd_t CMD_INH = 4'hf;
	localparam scs_cmd_t CMD_NOP = 4'h7;
	localparam scs_cmd_t CMD_ACT = 4'h3;
	localparam scs_cmd_t CMD_RD = 4'h5;
	localparam scs_cmd_t CMD_WR = 4'h4;
	localparam scs_cmd_t CMD_BT = 4'h6;
	localparam scs_cmd_t CMD_PRE = 4'h2;
	localparam scs_cmd_t CMD_REF = 4'h1;
	localparam scs_cmd_t CMD_LMR = 4'h0;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_LMR = 9'h002,
		ST_PRE = 9'h004,
		ST_ACT = 9'h008,
		ST_WAIT = 9'h010,
		ST_RD = 9'h020,
		ST_WR = 9'h040,
		ST_INH = 9'h080,
		ST_REF = 9'h100
	} scs_state_t;
	typedef struct packed {
		logic wr;
		logic hw_fetch;
		logic [2:0] len;
		logic [27:0] addr;
		logic [31:0] wdata;
	} scs_req_t;
endpackage

// ==== verilog/sdram_command_sequencer.sv ====
`timescale 1ns/1ps
module scs_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	if (D < 2 || (D & (D - 1)) != 0)
	begin : g_chk
		$error("fifo depth must be a power of two of at least 2");
	end
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic [AW:0] nxt_cnt;
	logic push;
	logic pop;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o = mem[rp_ff];
	always_ff @(posedge clock_i)
	begin
		if (push)
			mem[wp_ff] <= in_data_i;
	end
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end
		else
		begin
			wp_ff <= wp_ff + AW'(push);
			rp_ff <= rp_ff + AW'(pop);
			cnt_ff <= nxt_cnt;
			in_ready_o <= nxt_cnt != (AW+1)'(D);
			out_valid_o <= nxt_cnt != '0;
		end
	end
endmodule // scs_fifo

////////////////////////////////////////////////////////////////////////////////
module sdram_command_sequencer
	import scs_pkg::*;
#(
	parameter int REF_CYC = REFRESH_CYC,
	parameter int FIFO_D = MAX_LEN
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire scs_req_t req_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [31:0] rd_data_o,
	input wire logic mode_load_i,
	input wire logic row_strobe_out_i,
	input wire logic [1:0] port_size_i,
	input wire logic [1:0] wait_i,
	input wire logic other_req_i,
	output logic other_gnt_o,
	output logic cs_n_o,
	output logic row_strobe_out_o,
	output logic column_strobe_out_o,
	output logic write_enable_out_o,
	output logic autoprecharge_addr_out_o,
	output logic [ROW_W-1:0] addr_o,
	input wire logic [31:0] dq_i,
	output logic [31:0] dq_o,
	output logic dq_oe_o
);
	if (FIFO_D < MAX_LEN || REF_CYC < 16 || REF_CYC > 65535)
	begin : g_chk
		$error("fifo must hold a whole burst, refresh count 16..65535");
	end
	function automatic logic [23:0] ladr(input logic [27:0] a,
		input logic [1:0] ps);
		logic [27:0] s;
		s = (ps == PS_32) ? (a >> 2) : (ps == PS_16) ? (a >> 1) : a;
		return s[23:0];
	endfunction

	scs_state_t st_ff, nxt_st, aft_ff, nxt_aft;
	scs_req_t req_ff, cur;
	scs_cmd_t cmd_ff, nxt_cmd;
	logic [3:0] cnt_ff, nxt_cnt, casv, lastc;
	logic [3:0] open_ff;
	logic [ROW_W-1:0] row_ff [4];
	logic [23:0] la, la_req;
	logic [1:0] bank;
	logic hit, accept, push, fifo_rdy, cas_ff;
	logic ref_due_ff, mode_pend_ff, nxt_gnt, ref_wrap;
	logic [15:0] ref_cnt_ff;
	logic [ROW_W-1:0] addr_ff, nxt_addr;
	logic ap_ff, nxt_ap;

	assign cur = (st_ff == ST_IDLE) ? req_i : req_ff;
	assign la = ladr(cur.addr, port_size_i);
	assign la_req = ladr(req_ff.addr, port_size_i);
	assign bank = la[23:22];
	assign hit = open_ff[bank] && row_ff[bank] == la[21:8];
	assign accept = st_ff == ST_IDLE && req_valid_i && req_ready_o;
	assign casv = cas_ff ? 4'h3 : 4'h2;
	assign lastc = casv + {1'b0, req_ff.len} - 4'h1;
	assign push = st_ff == ST_RD && cnt_ff >= casv && cnt_ff <= lastc;
	assign nxt_gnt = other_req_i && st_ff == ST_IDLE && nxt_st == ST_IDLE
		&& !accept;
	assign ref_wrap = ref_cnt_ff == '0;
	assign cs_n_o = cmd_ff.cs_n;
	assign row_strobe_out_o = cmd_ff.ras_n;
	assign column_strobe_out_o = cmd_ff.cas_n;
	assign write_enable_out_o = cmd_ff.we_n;
	assign addr_o = addr_ff;
	assign autoprecharge_addr_out_o = ap_ff;

	////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb
	begin
		nxt_st = st_ff;
		nxt_aft = aft_ff;
		nxt_cnt = cnt_ff + 4'h1;
		case (st_ff)
			ST_IDLE:
			begin
				nxt_cnt = '0;
				if (accept)
				begin
					if (hit)
						nxt_st = req_i.wr ? ST_WR : ST_RD;
					else if (open_ff[bank])
					begin
						nxt_st = ST_PRE;
						nxt_aft = ST_ACT;
					end
					else
						nxt_st = ST_ACT;
				end
				else if (other_gnt_o)
					nxt_st = ST_IDLE;
				else if (mode_pend_ff)
					nxt_st = ST_LMR;
				else if (ref_due_ff)
				begin
					nxt_st = (|open_ff) ? ST_PRE : ST_REF;
					nxt_aft = ST_REF;
				end
			end
			ST_PRE:
			begin
				nxt_cnt = '0;
				nxt_st = (wait_i != 2'h0) ? ST_WAIT : aft_ff;
			end
			ST_ACT:
			begin
				nxt_cnt = '0;
				nxt_aft = req_ff.wr ? ST_WR : ST_RD;
				nxt_st = (wait_i != 2'h0) ? ST_WAIT : nxt_aft;
			end
			ST_REF:
			begin
				nxt_cnt = '0;
				nxt_aft = ST_IDLE;
				nxt_st = (wait_i != 2'h0) ? ST_WAIT : ST_IDLE;
			end
			ST_WAIT:
			begin
				if (cnt_ff == {2'h0, wait_i} - 4'h1)
				begin
					nxt_cnt = '0;
					nxt_st = aft_ff;
				end
			end
			ST_RD:
			begin
				if (cnt_ff == lastc)
				begin
					nxt_cnt = '0;
					nxt_st = ST_INH;
				end
			end
			ST_INH:
			begin
				if (cnt_ff == 4'(INH_CYC - 1))
					nxt_st = ST_IDLE;
			end
			ST_WR, ST_LMR:
				nxt_st = ST_IDLE;
			default:
				nxt_st = ST_IDLE;
		endcase
	end

	// command, address and a10 that go with the state being entered
	always_comb
	begin
		nxt_cmd = CMD_NOP;
		nxt_addr = '0;
		nxt_ap = 1'b0;
		case (nxt_st)
			ST_IDLE, ST_INH:
				nxt_cmd = CMD_INH;
			ST_PRE:
			begin
				nxt_cmd = CMD_PRE;
				nxt_ap = 1'b1;
			end
			ST_ACT:
			begin
				nxt_cmd = CMD_ACT;
				nxt_addr = la[21:8];
				nxt_ap = la[COL_W+AP_BIT];
			end
			ST_RD:
			begin
				if (nxt_cnt == '0)
				begin
					nxt_cmd = CMD_RD;
					nxt_addr = {{(ROW_W-COL_W){1'b0}}, la[COL_W-1:0]};
				end
				else if (nxt_cnt == lastc)
					nxt_cmd = CMD_BT;
			end
			ST_WR:
			begin
				nxt_cmd = CMD_WR;
				nxt_addr = {{(ROW_W-COL_W){1'b0}}, la[COL_W-1:0]};
			end
			ST_REF:
				nxt_cmd = CMD_REF;
			ST_LMR:
			begin
				nxt_cmd = CMD_LMR;
				nxt_addr = {4'h0, MODE_WB, 2'h0, row_strobe_out_i ? MODE_CL3 : MODE_CL2,
					MODE_BT, MODE_BL};
			end
			default:
				nxt_cmd = CMD_NOP;
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_ff <= ST_IDLE;
			aft_ff <= ST_IDLE;
			cnt_ff <= '0;
			cmd_ff <= CMD_INH;
			addr_ff <= '0;
			ap_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			aft_ff <= nxt_aft;
			cnt_ff <= nxt_cnt;
			cmd_ff <= nxt_cmd;
			addr_ff <= nxt_addr;
			ap_ff <= nxt_ap;
		end
	end

	// write data rides with the write command
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			dq_o <= '0;
			dq_oe_o <= 1'b0;
		end
		else
		begin
			dq_o <= cur.wdata;
			dq_oe_o <= nxt_st == ST_WR;
		end
	end

	// request capture; halfword fetch from 32-bit memory is one word
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			req_ff <= '0;
		else if (accept)
		begin
			req_ff <= req_i;
			if (req_i.len == 3'h0 || req_i.wr ||
				(port_size_i == PS_32 && req_i.hw_fetch))
				req_ff.len <= 3'h1;
			else if (req_i.len > 3'(MAX_LEN))
				req_ff.len <= 3'(MAX_LEN);
		end
	end

	// open row per bank
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			open_ff <= '0;
			for (int i = 0; i < 4; i++)
				row_ff[i] <= '0;
		end
		else if (nxt_st == ST_PRE && st_ff != ST_PRE)
			open_ff <= '0;
		else if (nxt_st == ST_ACT && st_ff != ST_ACT)
		begin
			open_ff[bank] <= 1'b1;
			row_ff[bank] <= la[21:8];
		end
	end

	// refresh timer, mode pending, cas latency, grant and ready
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ref_cnt_ff <= 16'(REF_CYC - 1);
			ref_due_ff <= 1'b0;
			mode_pend_ff <= 1'b0;
			cas_ff <= 1'b0;
			other_gnt_o <= 1'b0;
			req_ready_o <= 1'b0;
		end
		else
		begin
			ref_cnt_ff <= ref_wrap ? 16'(REF_CYC - 1) : ref_cnt_ff - 16'h1;
			if (ref_wrap)
				ref_due_ff <= 1'b1;
			else if (nxt_st == ST_REF && st_ff != ST_REF)
				ref_due_ff <= 1'b0;
			if (mode_load_i)
				mode_pend_ff <= 1'b1;
			else if (nxt_st == ST_LMR)
				mode_pend_ff <= 1'b0;
			if (nxt_st == ST_LMR)
				cas_ff <= row_strobe_out_i;
			other_gnt_o <= nxt_gnt;
			req_ready_o <= nxt_st == ST_IDLE && !nxt_gnt && !other_req_i
				&& !mode_pend_ff && !mode_load_i && !ref_due_ff
				&& !rd_valid_o;
		end
	end

	scs_fifo #(
		.W(32),
		.D(FIFO_D)
	) u_rd_fifo (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.in_valid_i(push),
		.in_ready_o(fifo_rdy),
		.in_data_i(dq_i),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_data_o(rd_data_o)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_rd_bt;
		@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_RD |-> ##[2:6] cmd_ff == CMD_BT;
	endproperty
	a_rd_bt: assert property (p_rd_bt) else $error("read not terminated");
	property p_bt_inh;
		@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_BT |=> cs_n_o [*2];
	endproperty
	a_bt_inh: assert property (p_bt_inh) else $error("inhibit short");
	property p_pre_ap;
		@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_PRE |-> autoprecharge_addr_out_o && open_ff == '0;
	endproperty
	a_pre_ap: assert property (p_pre_ap) else $error("precharge a10 low");
	property p_rw_ap;
		@(posedge clock_i) disable iff (!nrst_i)
		(cmd_ff == CMD_RD || cmd_ff == CMD_WR) |-> !autoprecharge_addr_out_o;
	endproperty
	a_rw_ap: assert property (p_rw_ap) else $error("autoprecharge asked");
	property p_gnt_inh;
		@(posedge clock_i) disable iff (!nrst_i)
		other_gnt_o |-> cs_n_o && $past(cs_n_o, 2);
	endproperty
	a_gnt_inh: assert property (p_gnt_inh) else $error("cs low in grant");
	property p_cas;
		@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_RD && !cas_ff |-> !push ##1 !push ##1 push;
	endproperty
	a_cas: assert property (p_cas) else $error("cas latency wrong");
	// a captured burst word must always find room in the read buffer
	property p_fifo;
		@(posedge clock_i) disable iff (!nrst_i)
		push |-> fifo_rdy;
	endproperty
	a_fifo: assert property (p_fifo) else $error("read word lost");
	property p_act_ap;
		@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_ACT |->
			autoprecharge_addr_out_o == la_req[COL_W+AP_BIT];
	endproperty
	a_act_ap: assert property (p_act_ap) else $error("active a10 bad");
	property p_hit;
		@(posedge clock_i) disable iff (!nrst_i)
		accept && hit |=> cmd_ff == CMD_RD || cmd_ff == CMD_WR;
	endproperty
	a_hit: assert property (p_hit) else $error("open row reopened");
	property p_miss;
		@(posedge clock_i) disable iff (!nrst_i)
		accept && open_ff[bank] && !hit |=> cmd_ff == CMD_PRE;
	endproperty
	a_miss: assert property (p_miss) else $error("row miss no precharge");
	property p_hw;
		@(posedge clock_i) disable iff (!nrst_i)
		accept && port_size_i == PS_32 && req_i.hw_fetch |=> req_ff.len == 3'h1;
	endproperty
	a_hw: assert property (p_hw) else $error("halfword burst");
	property p_lmr;
		@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_LMR |-> addr_o[6:4] == (cas_ff ? MODE_CL3 : MODE_CL2)
			&& addr_o[2:0] == MODE_BL;
	endproperty
	a_lmr: assert property (p_lmr) else $error("mode value wrong");
	c_rd: cover property (@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_RD ##[3:6] cmd_ff == CMD_BT);
	c_wr: cover property (@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_WR);
	c_ref: cover property (@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_PRE ##[1:4] cmd_ff == CMD_REF);
	c_gnt: cover property (@(posedge clock_i) disable iff (!nrst_i)
		cmd_ff == CMD_BT ##[3:8] other_gnt_o);
endmodule // sdram_command_sequencer

// ==== tb/scs_sdram_model.sv ====
`timescale 1ns/1ps
module scs_sdram_model
	import scs_pkg::*;
(
	input wire logic clock_i,
	input wire logic [3:0] cmd_i,
	input wire logic ap_i,
	input wire logic [ROW_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] dq_o
);
	logic [31:0] mem [logic [21:0]];
	logic [ROW_W-1:0] row = '0;
	logic [7:0] col = 8'h0;
	int cl = 2;
	int wt = 0;
	int tail = 0;
	logic on = 1'b0;

	function automatic logic [31:0] word(input logic [21:0] k);
		return mem.exists(k) ? mem[k] : (32'h5a000000 ^ {10'h0, k});
	endfunction

	initial dq_o = 32'h0;
	// burst runs on after terminate for two edges, then the bus toggles every edge
	always @(posedge clock_i)
	begin
		if (tail > 0)
		begin
			tail = tail - 1;
			if (tail == 0)
				on = 1'b0;
		end
		if (on && wt > 0)
			wt = wt - 1;
		else if (on)
		begin
			dq_o <= word({row, col});
			col = col + 8'h1;
		end
		else
			dq_o <= ~dq_o;
		case (cmd_i)
			CMD_LMR: cl = (addr_i[6:4] == 3'h3) ? 3 : 2;
			CMD_ACT:
			begin
				row = addr_i;
				row[AP_BIT] = ap_i;
			end
			CMD_RD:
			begin
				on = 1'b1;
				col = addr_i[7:0];
				wt = cl - 2;
				tail = 0;
			end
			CMD_WR: mem[{row, addr_i[7:0]}] = wdata_i;
			CMD_BT: tail = 2;
			default: ;
		endcase
	end
endmodule // scs_sdram_model

// ==== tb/test_sdram_command_sequencer.sv ====
`timescale 1ns/1ps
module test_sdram_command_sequencer
	import scs_pkg::*;
();
	localparam int REF = 1500;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic req_valid_i = 1'b0;
	scs_req_t req_i = '0;
	logic rd_ready_i = 1'b0;
	logic mode_load_i = 1'b0;
	logic row_strobe_out_i = 1'b0;
	logic [1:0] port_size_i = PS_32;
	logic [1:0] wait_i = 2'h1;
	logic other_req_i = 1'b0;
	logic req_ready_o, rd_valid_o, other_gnt_o, cs_n_o, row_strobe_out_o;
	logic column_strobe_out_o, write_enable_out_o, autoprecharge_addr_out_o;
	logic dq_oe_o;
	logic [31:0] rd_data_o, dq_o, dq_i;
	logic [ROW_W-1:0] addr_o;
	logic [3:0] cmd;
	int num_errors = 0;
	int samples_checked = 0;
	int n_cmd [16] = '{default: 0};
	int n0 [16];
	logic l_ap [16];
	logic [ROW_W-1:0] l_addr [16];
	logic [31:0] l_wd;
	logic l_oe;
	int gap = 9;
	logic gnt_q = 1'b0;
	int cyc = 0;

	sdram_command_sequencer #(.REF_CYC(REF)) i_dut (.clock_i, .nrst_i,
		.req_valid_i, .req_ready_o, .req_i, .rd_valid_o, .rd_ready_i,
		.rd_data_o, .mode_load_i, .row_strobe_out_i, .port_size_i, .wait_i,
		.other_req_i, .other_gnt_o, .cs_n_o, .row_strobe_out_o,
		.column_strobe_out_o, .write_enable_out_o, .autoprecharge_addr_out_o,
		.addr_o, .dq_i, .dq_o, .dq_oe_o);
	scs_sdram_model i_mem (.clock_i, .cmd_i(cmd),
		.ap_i(autoprecharge_addr_out_o), .addr_i(addr_o), .wdata_i(dq_o),
		.dq_o(dq_i));
	assign cmd = cs_n_o ? CMD_INH : {cs_n_o, row_strobe_out_o,
		column_strobe_out_o, write_enable_out_o};

	initial forever #4 clock_i = ~clock_i;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			stop_test;
		end
	end

	// command monitor, sampled mid-cycle where outputs are settled
	always @(negedge clock_i)
	begin
		if (nrst_i)
		begin
			n_cmd[cmd]++;
			l_ap[cmd] = autoprecharge_addr_out_o;
			l_addr[cmd] = addr_o;
			if (cmd == CMD_WR)
			begin
				l_wd = dq_o;
				l_oe = dq_oe_o;
			end
			if (other_gnt_o === 1'b1 && !gnt_q)
				chk("bt_gap", 1, gap >= 2);
			if (other_gnt_o === 1'b1)
				chk("gnt_cs", 1, cs_n_o);
			gap = (cmd == CMD_BT) ? 0 : (cmd == CMD_INH) ? gap + 1 : gap;
			gnt_q = other_gnt_o;
		end
	end

	function automatic int d(input logic [3:0] c);
		return n_cmd[c] - n0[c];
	endfunction

	function automatic logic [21:0] key(input logic [27:0] a, input int sh);
		return 22'(a >> sh);
	endfunction

	function automatic logic [31:0] pat(input logic [27:0] a, input int sh);
		return 32'h5a000000 | {10'h0, key(a, sh)};
	endfunction

	task automatic until_cmd(input logic [3:0] c, input int k0);
		int t;
		t = 0;
		while (n_cmd[c] == k0 && t < 3000)
		begin
			@(negedge clock_i);
			t++;
		end
	endtask

	task automatic issue(input logic wr, input logic hw, input logic [2:0] len,
		input logic [27:0] a, input logic [31:0] wd);
		int k;
		req_i = '{wr, hw, len, a, wd};
		req_valid_i = 1'b1;
		k = 0;
		while (req_ready_o !== 1'b1 && k < 300)
		begin
			@(negedge clock_i);
			k++;
		end
		chk("taken", 1, req_ready_o);
		n0 = n_cmd;
		@(negedge clock_i);
		req_valid_i = 1'b0;
	endtask

	// consumer stalls first so the burst piles up in the read buffer
	task automatic get_words(input int n, input logic [31:0] e);
		int t;
		repeat (8) @(negedge clock_i);
		for (int i = 0; i < n; i++)
		begin
			t = 0;
			while (rd_valid_o !== 1'b1 && t < 50)
			begin
				@(negedge clock_i);
				t++;
			end
			chk("rdata", e + i, rd_data_o);
			rd_ready_i = 1'b1;
			@(negedge clock_i);
			rd_ready_i = 1'b0;
		end
		repeat (6) @(negedge clock_i);
		chk("extra_word", 0, rd_valid_o);
	endtask

	task automatic t_read(input string nm, input logic [27:0] a,
		input logic [2:0] len, input logic hw, input int sh, input int act,
		input int pre, input logic [31:0] e);
		logic [21:0] k;
		k = key(a, sh);
		issue(1'b0, hw, len, a, 32'h0);
		get_words(hw ? 1 : int'(len), e);
		chk("n_act", act, d(CMD_ACT));
		chk("n_pre", pre, d(CMD_PRE));
		chk("n_rd", 1, d(CMD_RD));
		chk("n_bt", 1, d(CMD_BT));
		chk("rd_ap", 0, l_ap[CMD_RD]);
		chk("rd_col", k[7:0], l_addr[CMD_RD][7:0]);
		if (act > 0)
			chk("act_ap", a[18 + sh], l_ap[CMD_ACT]);
		if (pre > 0)
			chk("pre_ap", 1, l_ap[CMD_PRE]);
		$display("test %s done", nm);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_mode(input logic c3);
		int k0;
		k0 = n_cmd[CMD_LMR];
		row_strobe_out_i = c3;
		mode_load_i = 1'b1;
		@(negedge clock_i);
		mode_load_i = 1'b0;
		until_cmd(CMD_LMR, k0);
		chk("lmr_cnt", k0 + 1, n_cmd[CMD_LMR]);
		chk("lmr_val", {7'h4, c3 ? 3'h3 : 3'h2, 4'h7}, l_addr[CMD_LMR]);
		$display("test mode done");
	endtask

	task automatic t_rows;
		t_read("miss", 28'h0100404, 3'h1, 1'b0, 2, 1, 0,
			pat(28'h0100404, 2));
		t_read("hit", 28'h010040c, 3'h4, 1'b0, 2, 0, 0,
			pat(28'h010040c, 2));
		t_read("row", 28'h0000804, 3'h2, 1'b0, 2, 1, 1,
			pat(28'h0000804, 2));
		t_read("bank", 28'h1000804, 3'h1, 1'b0, 2, 1, 0,
			pat(28'h0000804, 2));
	endtask

	task automatic t_write;
		issue(1'b1, 1'b0, 3'h1, 28'h0000810, 32'hcafe1234);
		repeat (6) @(negedge clock_i);
		chk("wr_cnt", 1, d(CMD_WR));
		chk("wr_act", 0, d(CMD_ACT));
		chk("wr_col", 4, l_addr[CMD_WR][7:0]);
		chk("wr_data", 32'hcafe1234, l_wd);
		chk("wr_oe", 1, l_oe);
		chk("wr_ap", 0, l_ap[CMD_WR]);
		t_read("readback", 28'h0000810, 3'h1, 1'b0, 2, 0, 0,
			32'hcafe1234);
		t_read("halfword", 28'h0000820, 3'h4, 1'b1, 2, 0, 0,
			pat(28'h0000820, 2));
	endtask

	task automatic t_ports;
		logic [27:0] a;
		for (int sh = 2; sh >= 0; sh--)
		begin
			port_size_i = (sh == 2) ? PS_32 : (sh == 1) ? PS_16 : PS_8;
			// wait states 2, 1 and 0 after precharge and active
			wait_i = 2'(sh);
			a = (28'h1 << (18 + sh)) | (28'(3 - sh) << (8 + sh));
			t_read("port", a, 3'h1, 1'b0, sh, 1, 1, pat(a, sh));
		end
		port_size_i = PS_32;
		wait_i = 2'h1;
	endtask

	task automatic t_grant;
		int t;
		issue(1'b0, 1'b0, 3'h1, 28'h0000804, 32'h0);
		other_req_i = 1'b1;
		get_words(1, pat(28'h0000804, 2));
		t = 0;
		while (other_gnt_o !== 1'b1 && t < 50)
		begin
			@(negedge clock_i);
			t++;
		end
		chk("gnt", 1, other_gnt_o);
		repeat (4) @(negedge clock_i);
		chk("gnt_busy", 0, req_ready_o);
		other_req_i = 1'b0;
		repeat (2) @(negedge clock_i);
		chk("gnt_off", 0, other_gnt_o);
		$display("test grant done");
	endtask

	task automatic t_refresh;
		int t;
		until_cmd(CMD_REF, n_cmd[CMD_REF]);
		chk("ref_seen", 1, n_cmd[CMD_REF] > 0);
		t = 0;
		until_cmd(CMD_REF, n_cmd[CMD_REF]);
		t = n_cmd[CMD_INH] + n_cmd[CMD_NOP] + n_cmd[CMD_PRE];
		chk("ref_twice", 2, n_cmd[CMD_REF]);
		t_read("cl3", 28'h0000804, 3'h2, 1'b0, 2, 1, 0,
			pat(28'h0000804, 2));
	endtask

	initial
	begin
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		nrst_i = 1'b1;
		repeat (2) @(negedge clock_i);
		t_mode(1'b0);
		t_rows;
		t_write;
		t_ports;
		t_grant;
		t_mode(1'b1);
		t_refresh;
		stop_test;
	end
endmodule // test_sdram_command_sequencer
